/* flut_regs.vh */
// Register offsets, fields, reset values and timing for the ninth lookup point
`ifndef FLUT_REGS_VH
`define FLUT_REGS_VH

// Register indices; not all are word aligned, so each takes the word at four times its index
`define FLUT_IDX_TBL_CTRL     8'h4a
`define FLUT_IDX_TEMP_OFFSET  8'h4e
`define FLUT_IDX_MODE         8'h50
`define FLUT_IDX_P8_DUTY      8'h5f
`define FLUT_IDX_P9_LIMIT     8'h60
`define FLUT_IDX_P9_DUTY      8'h61
`define FLUT_IDX_STATUS       8'h68

// Byte addresses of the APB-visible registers (four times the index)
`define FLUT_OFF_TBL_CTRL     12'h128
`define FLUT_OFF_TEMP_OFFSET  12'h138
`define FLUT_OFF_MODE         12'h140
`define FLUT_OFF_P8_DUTY      12'h17c
`define FLUT_OFF_P9_LIMIT     12'h180
`define FLUT_OFF_P9_DUTY      12'h184
`define FLUT_OFF_STATUS       12'h1a0

// Field positions
`define FLUT_CTRL_WREN_BIT    5
`define FLUT_MODE_TEMP_HI_BIT 0
`define FLUT_MODE_DUTY_HI_BIT 1
`define FLUT_MODE_F22K5_BIT   2

// Reset values
`define FLUT_RST_P9_LIMIT     8'h7f
`define FLUT_RST_P9_DUTY      8'h3f
`define FLUT_RST_P8_DUTY      6'h3f
`define FLUT_RST_TBL_CTRL     8'h00
`define FLUT_RST_TEMP_OFFSET  8'h00
`define FLUT_RST_MODE         3'h0

// Timing: the APB slave answers in the access phase with no wait states
`define FLUT_APB_WAIT_CYC     0

`endif

/* flut_cmp.v */
// Limit compare for the ninth lookup point
`timescale 1ns/1ps
module flut_cmp (
    // Mode and operands
    input  wire        temp_hi,
    input  wire [7:0]  limit_raw,
    input  wire [7:0]  offset,
    input  wire [8:0]  temp_meas,
    // Result
    output wire        above
);
    wire [9:0] lim_half;
    wire [9:0] meas_cmp;

    // Limit in half-degree units: bits 6:0 are whole degrees, bit 7 the half degree
    // Sign taken as zero, offset added in whole degrees
    assign lim_half = temp_hi ?
        ({2'b00, limit_raw[6:0], limit_raw[7]} + {1'b0, offset, 1'b0}) :
        ({2'b00, 1'b0, limit_raw[6:0]} + {2'b00, offset}) << 1;
    // Low resolution drops the half-degree bit of the reading
    assign meas_cmp = temp_hi ? {1'b0, temp_meas} : {1'b0, temp_meas[8:1], 1'b0};
    assign above    = meas_cmp > lim_half;
endmodule // flut_cmp

/* flut_duty.v */
// Duty selection for the ninth and eighth lookup points
`timescale 1ns/1ps
module flut_duty (
    // Modes
    input  wire        duty_hi,
    input  wire        f22k5,
    // Stored duty values
    input  wire [7:0]  p9_duty,
    input  wire [5:0]  p8_duty,
    // Effective values
    output wire [7:0]  p9_eff,
    output wire [7:0]  p8_eff
);
    wire ext_on;

    // Extension bits only count in high-res duty mode at 22.5 kHz
    assign ext_on = duty_hi & f22k5;
    assign p9_eff = ext_on ? p9_duty : {2'b00, p9_duty[5:0]};
    assign p8_eff = {2'b00, p8_duty};
endmodule // flut_duty

/* flut_top.v */
// APB register bank and compare for the ninth fan lookup point
`timescale 1ns/1ps
`include "flut_regs.vh"
module flut_top (
    // Clock and reset
    input  wire        SYS_CLK,
    input  wire        SRST,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // Temperature from the measurement logic, half-degree units
    input  wire [8:0]  TEMP_MEAS,
    input  wire        TEMP_VALID,
    // Fan PWM request
    output reg         PWM_SEL,
    output reg  [7:0]  PWM_DUTY
);
    reg  [7:0] p9_limit_reg;
    reg  [7:0] p9_duty_reg;
    reg  [5:0] p8_duty_reg;
    reg  [7:0] tbl_ctrl_reg;
    reg  [7:0] temp_offset_reg;
    reg  [2:0] mode_reg;
    reg  [8:0] temp_reg;
    reg  [31:0] rd_next;
    reg        err_next;
    wire       above;
    wire [7:0] p9_eff;
    wire [7:0] p8_eff;
    wire       wr_ok;
    wire       temp_hi;
    wire       duty_hi;
    wire       access;

    assign temp_hi = mode_reg[`FLUT_MODE_TEMP_HI_BIT];
    assign duty_hi = mode_reg[`FLUT_MODE_DUTY_HI_BIT];
    assign access  = PSEL & PENABLE;
    assign wr_ok   = tbl_ctrl_reg[`FLUT_CTRL_WREN_BIT];

    // Read-back decode; limit bit 7 reads as zero unless temp_hi, duty bits 7:6 unless duty_hi
    function [31:0] rd_mux;
        input [11:0] a;
        begin
            case (a)
                `FLUT_OFF_TBL_CTRL:    rd_mux = {24'h000000, tbl_ctrl_reg};
                `FLUT_OFF_TEMP_OFFSET: rd_mux = {24'h000000, temp_offset_reg};
                `FLUT_OFF_MODE:        rd_mux = {29'h0, mode_reg};
                `FLUT_OFF_P8_DUTY:     rd_mux = {26'h0, p8_duty_reg};
                `FLUT_OFF_P9_LIMIT:    rd_mux = {24'h000000,
                                       temp_hi & p9_limit_reg[7], p9_limit_reg[6:0]};
                `FLUT_OFF_P9_DUTY:     rd_mux = {24'h000000,
                                       duty_hi ? p9_duty_reg[7:6] : 2'b00,
                                       p9_duty_reg[5:0]};
                `FLUT_OFF_STATUS:      rd_mux = {23'h0, above, temp_reg[7:0]};
                default:               rd_mux = 32'h00000000;
            endcase
        end
    endfunction

    // Unmapped address decode
    function mapped;
        input [11:0] a;
        begin
            case (a)
                `FLUT_OFF_TBL_CTRL, `FLUT_OFF_TEMP_OFFSET, `FLUT_OFF_MODE,
                `FLUT_OFF_P8_DUTY, `FLUT_OFF_P9_LIMIT, `FLUT_OFF_P9_DUTY,
                `FLUT_OFF_STATUS: mapped = 1'b1;
                default:          mapped = 1'b0;
            endcase
        end
    endfunction

    // Combinational read data and error for the access phase
    always @* begin
        rd_next  = rd_mux(PADDR);
        err_next = ~mapped(PADDR);
    end

    // Register writes; table points locked unless enabled, control, offset and mode always writable
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            p9_limit_reg    <= `FLUT_RST_P9_LIMIT;
            p9_duty_reg     <= `FLUT_RST_P9_DUTY;
            p8_duty_reg     <= `FLUT_RST_P8_DUTY;
            tbl_ctrl_reg    <= `FLUT_RST_TBL_CTRL;
            temp_offset_reg <= `FLUT_RST_TEMP_OFFSET;
            mode_reg        <= `FLUT_RST_MODE;
        end else if (access & PWRITE & PREADY) begin
            case (PADDR)
                `FLUT_OFF_TBL_CTRL:    tbl_ctrl_reg    <= PWDATA[7:0];
                `FLUT_OFF_TEMP_OFFSET: temp_offset_reg <= PWDATA[7:0];
                `FLUT_OFF_MODE:        mode_reg        <= PWDATA[2:0];
                `FLUT_OFF_P8_DUTY:     if (wr_ok) p8_duty_reg  <= PWDATA[5:0];
                `FLUT_OFF_P9_LIMIT:    if (wr_ok) p9_limit_reg <= PWDATA[7:0];
                `FLUT_OFF_P9_DUTY:     if (wr_ok) p9_duty_reg  <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // APB answer: ready during every access phase, registered outputs
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL & ~PENABLE;
            PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? rd_next : 32'h00000000;
            PSLVERR <= PSEL & ~PENABLE & err_next;
        end
    end

    // Sample temperature; it comes from logic on this clock, so no synchroniser
    always @(posedge SYS_CLK) begin
        if (SRST)
            temp_reg <= 9'h000;
        else if (TEMP_VALID)
            temp_reg <= TEMP_MEAS;
    end

    flut_cmp u_cmp (
        .temp_hi   (temp_hi),
        .limit_raw (p9_limit_reg),
        .offset    (temp_offset_reg),
        .temp_meas (temp_reg),
        .above     (above)
    );

    flut_duty u_duty (
        .duty_hi (duty_hi),
        .f22k5   (mode_reg[`FLUT_MODE_F22K5_BIT]),
        .p9_duty (p9_duty_reg),
        .p8_duty (p8_duty_reg),
        .p9_eff  (p9_eff),
        .p8_eff  (p8_eff)
    );

    // Fan duty: point nine while above its limit, else point eight as the step below
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            PWM_SEL  <= 1'b0;
            PWM_DUTY <= 8'h00;
        end else begin
            PWM_SEL  <= above;
            PWM_DUTY <= above ? p9_eff : p8_eff;
        end
    end
endmodule // flut_top

/* flut_temp_src.sv */
// Remote temperature source model feeding the bank
`timescale 1ns/1ps
module flut_temp_src (
    // Clock and bench request
    input  wire logic       clk,
    input  wire logic       req,
    input  wire logic [8:0] t_in,
    // Measurement toward the bank
    output logic      [8:0] temp_meas,
    output logic            temp_valid
);
    initial temp_meas = 9'h155;
    // Outside the pulse the bus toggles, so a stale value never looks loaded
    always @(posedge clk) begin
        temp_valid <= req;
        temp_meas  <= req ? t_in : ~temp_meas;
    end
endmodule // flut_temp_src

/* flut_top_sva.sv */
// Checker for the ninth-point register bank
`timescale 1ns/1ps
`include "flut_regs.vh"
module flut_top_sva (
    // Clock and reset
    input wire        SYS_CLK,
    input wire        SRST,
    // Register bus
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    // Temperature and fan request
    input wire [8:0]  TEMP_MEAS,
    input wire        TEMP_VALID,
    input wire        PWM_SEL,
    input wire [7:0]  PWM_DUTY
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    logic [7:0] lim_reg, d9_reg, off_reg;
    logic [5:0] p8_reg;
    logic [2:0] md_reg;
    logic       we_reg;
    wire wr = PSEL && PENABLE && PREADY && PWRITE;
    wire rd = PSEL && PENABLE && PREADY && !PWRITE;
    // Offset counts whole degrees, so it doubles in half-degree units
    wire abv = md_reg[0]
        ? {1'b0, TEMP_MEAS} > {2'b0, lim_reg[6:0], lim_reg[7]} + {1'b0, off_reg, 1'b0}
        : {2'b0, TEMP_MEAS[8:1]} > {3'b0, lim_reg[6:0]} + {2'b0, off_reg};
    wire [7:0] d9e = (md_reg[1] && md_reg[2]) ? d9_reg : {2'b0, d9_reg[5:0]};
    // Shadow copy of the registers, updated only on committed writes
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            lim_reg <= `FLUT_RST_P9_LIMIT;
            d9_reg  <= `FLUT_RST_P9_DUTY;
            p8_reg  <= `FLUT_RST_P8_DUTY;
            off_reg <= `FLUT_RST_TEMP_OFFSET;
            md_reg  <= `FLUT_RST_MODE;
            we_reg  <= 1'b0;
        end else if (wr) begin
            if (PADDR == `FLUT_OFF_TBL_CTRL) we_reg <= PWDATA[`FLUT_CTRL_WREN_BIT];
            if (PADDR == `FLUT_OFF_TEMP_OFFSET) off_reg <= PWDATA[7:0];
            if (PADDR == `FLUT_OFF_MODE) md_reg <= PWDATA[2:0];
            if (we_reg && PADDR == `FLUT_OFF_P9_LIMIT) lim_reg <= PWDATA[7:0];
            if (we_reg && PADDR == `FLUT_OFF_P9_DUTY) d9_reg <= PWDATA[7:0];
            if (we_reg && PADDR == `FLUT_OFF_P8_DUTY) p8_reg <= PWDATA[5:0];
        end
    end
    a_limit_back: assert property (
        rd && PADDR == `FLUT_OFF_P9_LIMIT |-> PRDATA[7:0] == {lim_reg[7] & md_reg[0], lim_reg[6:0]})
        else $error("limit readback wrong");
    a_limit_top: assert property (
        rd && PADDR == `FLUT_OFF_P9_LIMIT && !md_reg[0] |-> !PRDATA[7])
        else $error("limit top bit not zero");
    a_duty_back: assert property (
        rd && PADDR == `FLUT_OFF_P9_DUTY |-> PRDATA[7:0] == {d9_reg[7:6] & {2{md_reg[1]}}, d9_reg[5:0]})
        else $error("duty readback wrong");
    a_duty_top: assert property (
        rd && PADDR == `FLUT_OFF_P9_DUTY && !md_reg[1] |-> PRDATA[7:6] == 2'b00)
        else $error("duty top bits not zero");
    a_p8_back: assert property (
        rd && PADDR == `FLUT_OFF_P8_DUTY |-> PRDATA[7:0] == {2'b00, p8_reg})
        else $error("point eight readback wrong");
    // Temperature loads at the pulse edge, the fan request one edge later
    a_sel_cmp: assert property (
        TEMP_VALID |=> ##1 PWM_SEL == $past(abv, 2)) else $error("compare result wrong");
    a_duty_pick: assert property (
        TEMP_VALID |=> ##1 PWM_DUTY == ($past(abv, 2) ? $past(d9e, 2) : {2'b00, $past(p8_reg, 2)}))
        else $error("fan duty wrong");
    a_ext_gate: assert property (
        TEMP_VALID && !md_reg[2] |=> ##1 PWM_DUTY[7:6] == 2'b00) else $error("extension leaked");
    c_above: cover property (TEMP_VALID ##2 PWM_SEL);
    c_refused: cover property (wr && !we_reg && PADDR == `FLUT_OFF_P9_LIMIT);
    c_unmapped: cover property (PREADY && PSLVERR);
endmodule // flut_top_sva
bind flut_top flut_top_sva u_sva (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TEMP_MEAS(TEMP_MEAS), .TEMP_VALID(TEMP_VALID),
    .PWM_SEL(PWM_SEL), .PWM_DUTY(PWM_DUTY));

/* testbench.sv */
// Self-checking bench for the ninth-point register bank
`timescale 1ns/1ps
`include "flut_regs.vh"
module testbench;
    logic        clk, srst, psel, pen, pwr, req, rdy, serr, sel, tvld, err;
    logic [11:0] pa;
    logic [31:0] pw, pr, q;
    logic [8:0]  tv, tm;
    logic [7:0]  duty;
    int          err_total, n_compared;
    flut_top dut (.SYS_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pw), .PRDATA(pr), .PREADY(rdy), .PSLVERR(serr),
        .TEMP_MEAS(tm), .TEMP_VALID(tvld), .PWM_SEL(sel), .PWM_DUTY(duty));
    flut_temp_src src (.clk(clk), .req(req), .t_in(tv), .temp_meas(tm), .temp_valid(tvld));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task close_out;
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus transfer; request held until ready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1; pwr <= w; pa <= a; pw <= d;
        @(posedge clk);
        pen <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (rdy === 1'b1) break;
        end
        if (i == 20) begin err_total++; close_out; end
        q = pr;
        err = serr;
        psel <= 0; pen <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d); apb(1, a, {24'h0, d}); endtask
    task rd(input logic [11:0] a, input logic [7:0] e); apb(0, a, 0); chk(q, {24'h0, e}); endtask
    // Model pulses, bank loads, fan request updates; look one edge after that
    task tp(input logic [8:0] t, input logic s, input logic [7:0] e);
        @(posedge clk); req <= 1; tv <= t;
        @(posedge clk); req <= 0;
        repeat (3) @(posedge clk);
        chk({23'h0, sel, duty}, {23'h0, s, e});
    endtask
    initial begin
        srst = 1; psel = 0; pen = 0; pwr = 0; req = 0; pa = 0; pw = 0; tv = 0;
        err_total = 0; n_compared = 0;
        repeat (5) @(posedge clk);
        srst <= 0;
        rd(`FLUT_OFF_P9_LIMIT, 8'h7f);
        rd(`FLUT_OFF_P9_DUTY, 8'h3f);
        rd(`FLUT_OFF_P8_DUTY, 8'h3f);
        wr(`FLUT_OFF_P9_LIMIT, 8'h55);
        rd(`FLUT_OFF_P9_LIMIT, 8'h7f);
        apb(0, 12'h070, 0); chk({31'h0, err}, 1);
        wr(`FLUT_OFF_TBL_CTRL, 8'h20);
        wr(`FLUT_OFF_P8_DUTY, 8'h15);
        wr(`FLUT_OFF_P9_LIMIT, 8'hb2);
        wr(`FLUT_OFF_P9_DUTY, 8'hc7);
        rd(`FLUT_OFF_P9_LIMIT, 8'h32);
        rd(`FLUT_OFF_P9_DUTY, 8'h07);
        tp(9'd101, 0, 8'h15);
        tp(9'd102, 1, 8'h07);
        wr(`FLUT_OFF_MODE, 8'h03);
        rd(`FLUT_OFF_P9_LIMIT, 8'hb2);
        rd(`FLUT_OFF_P9_DUTY, 8'hc7);
        tp(9'd101, 0, 8'h15);
        tp(9'd102, 1, 8'h07);
        wr(`FLUT_OFF_MODE, 8'h07);
        tp(9'd102, 1, 8'hc7);
        wr(`FLUT_OFF_TEMP_OFFSET, 8'h0a);
        tp(9'd121, 0, 8'h15);
        tp(9'd122, 1, 8'hc7);
        close_out;
    end
endmodule // testbench
